// ==== hw/pci_parity_latency_ctrl_map.vh ====
`ifndef PCI_PARITY_LATENCY_CTRL_MAP_VH
`define PCI_PARITY_LATENCY_CTRL_MAP_VH

// Register byte offsets.
`define CTRL_ADDR 12'h000
`define LAT_ADDR 12'h004
`define STAT_ADDR 12'h008

// Control register fields.
`define CTRL_PERR_EN 0
`define CTRL_POST_EN 1
`define CTRL_RESET 2'h0

// Latency register reset value.
`define LAT_RESET 8'h00

// Status register fields.
`define STAT_PERR 0
`define STAT_EXPIRED 1
`define STAT_FULL 2
`define STAT_BUFS_LSB 4

// Bus commands carried on the command lines.
`define CMD_IO_READ 4'h2
`define CMD_IO_WRITE 4'h3
`define CMD_MEM_READ 4'h6
`define CMD_MEM_WRITE 4'h7

// Cycles without a device select before a master abort.
`define DEVSEL_WAIT 3'h5

`endif

// ==== hw/master_latency_timer.v ====
`timescale 1ns/1ns
module master_latency_timer #(
  parameter WIDTH = 8
) (
  input wire pclk,
  input wire presetn,
  input wire frame_active,
  input wire [WIDTH-1:0] slice,
  output reg expired
);
  reg [WIDTH-1:0] count;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= {WIDTH{1'b0}};
      expired <= 1'b0;
    end else if (!frame_active) begin
      count <= {WIDTH{1'b0}};
      expired <= 1'b0;
    end else begin
      if (count != slice) begin
        count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
      end
      expired <= (count == slice) || expired;
    end
  end
endmodule

// ==== hw/bus_parity_unit.v ====
`timescale 1ns/1ns
module bus_parity_unit (
  input wire pclk,
  input wire presetn,
  input wire ad_drive,
  input wire [31:0] ad_out,
  input wire cbe_drive,
  input wire [3:0] cbe_n_out,
  input wire [31:0] ad_in,
  input wire [3:0] cbe_n_in,
  input wire par_in,
  input wire check,
  input wire perr_en,
  output reg par_out,
  output reg par_oe,
  output reg perr_n_out,
  output reg perr_oe,
  output reg error
);
  reg chk_pend;
  reg chk_par;
  wire [3:0] cbe_src = cbe_drive ? cbe_n_out : cbe_n_in;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      par_out <= 1'b0;
      par_oe <= 1'b0;
      chk_pend <= 1'b0;
      chk_par <= 1'b0;
      error <= 1'b0;
      perr_n_out <= 1'b1;
      perr_oe <= 1'b0;
    end else begin
      // Even parity over all lanes, meaningful or not, one clock after the data.
      par_out <= ^{ad_out, cbe_src};
      par_oe <= ad_drive;
      chk_pend <= check;
      chk_par <= ^{ad_in, cbe_n_in};
      error <= chk_pend && (chk_par != par_in);
      if (error && perr_en) begin
        perr_n_out <= 1'b0;
        perr_oe <= 1'b1;
      end else if (perr_oe && !perr_n_out) begin
        perr_n_out <= 1'b1;
      end else begin
        perr_oe <= 1'b0;
      end
    end
  end
endmodule

// ==== hw/pci_parity_latency_ctrl.v ====
// Operation
// - Latency timer zero unless bridge drives frame.
// - Timer counts clocks from own frame assertion.
// - Expired and grant lost: end master transaction.
// - Post memory writes while enabled, owned, free.
// - Buffers full: disconnect burst, retry single.
// - Other downstream cycles stop after first phase.
// - Even parity over data, command, parity lines.
// - Idle lanes stay stable, still counted.
// - Master drives parity one clock after data.
// - No address phase parity check as target.
// - Read master checks returned data parity.
// - Write target checks parity one clock later.
// - Read target drives parity next clock.
// - Error signal only when participating and enabled.
// - Error signal driven then released.
// - Parity error status set even when disabled.
// - Bridge never drives system error.
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ns
`include "pci_parity_latency_ctrl_map.vh"
module pci_parity_latency_ctrl #(
  parameter BUFFERS = 4,
  parameter [7:0] TARGET_BASE = 8'h80
) (
  input wire pclk,
  input wire presetn,
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire frame_n_in,
  input wire irdy_n_in,
  input wire trdy_n_in,
  input wire stop_n_in,
  input wire devsel_n_in,
  input wire [31:0] ad_in,
  input wire [3:0] cbe_n_in,
  input wire par_in,
  input wire gnt_n,
  output reg req_n,
  output reg frame_n_out,
  output reg frame_oe,
  output reg irdy_n_out,
  output reg irdy_oe,
  output reg trdy_n_out,
  output reg stop_n_out,
  output reg devsel_n_out,
  output reg target_oe,
  output reg [31:0] ad_out,
  output reg ad_oe,
  output reg [3:0] cbe_n_out,
  output reg cbe_oe,
  output wire par_out,
  output wire par_oe,
  output wire perr_n_out,
  output wire perr_oe,
  input wire eisa_owned,
  input wire buf_drain,
  input wire [31:0] t_rdata,
  output reg post_strobe,
  output reg [31:0] post_data,
  output reg [3:0] post_be_n,
  input wire m_start,
  input wire [3:0] m_cmd,
  input wire [31:0] m_addr,
  input wire [31:0] m_wdata,
  input wire [3:0] m_phases,
  output reg m_busy,
  output reg m_rvalid,
  output reg [31:0] m_rdata
);
  localparam M_IDLE = 4'b0001;
  localparam M_ADDR = 4'b0010;
  localparam M_DATA = 4'b0100;
  localparam M_TURN = 4'b1000;
  localparam T_IDLE = 4'b0001;
  localparam T_RTURN = 4'b0010;
  localparam T_DATA = 4'b0100;
  localparam T_BACK = 4'b1000;

  reg [1:0] ctrl;
  reg [7:0] slice;
  reg perr_flag;
  reg [3:0] m_state;
  reg [3:0] t_state;
  reg m_pend;
  reg m_write;
  reg [3:0] m_left;
  reg [2:0] m_devwait;
  reg frame_prev;
  reg t_write;
  reg t_post;
  reg [3:0] bufs;
  wire expired;
  wire parity_error;

  wire [3:0] a_cmd = cbe_n_in;
  wire a_phase = !frame_n_in && frame_prev && (m_state == M_IDLE);
  wire a_known = (a_cmd == `CMD_MEM_READ) || (a_cmd == `CMD_MEM_WRITE) ||
    (a_cmd == `CMD_IO_READ) || (a_cmd == `CMD_IO_WRITE);
  // Address parity is never checked here, and no system error exists.
  wire a_hit = a_phase && (ad_in[31:24] == TARGET_BASE) && a_known;
  wire a_post = a_cmd == `CMD_MEM_WRITE;
  wire full = bufs == BUFFERS[3:0];
  wire post_ok = ctrl[`CTRL_POST_EN] && eisa_owned && !full;
  wire t_xfer = (t_state == T_DATA) && !irdy_n_in && !trdy_n_out;
  wire m_xfer = (m_state == M_DATA) && !irdy_n_out && !trdy_n_in;
  wire post_xfer = t_xfer && t_post;
  wire [3:0] bufs_next = bufs + {3'h0, post_xfer} - {3'h0, buf_drain};
  // Only data phases the bridge receives are checked: master reads and target writes.
  wire check = (m_xfer && !m_write) || (t_xfer && t_write);
  wire grant_lost = expired && gnt_n;

  wire apb_hit = (paddr == `CTRL_ADDR) || (paddr == `LAT_ADDR) || (paddr == `STAT_ADDR);
  wire apb_wr = psel && penable && pready && pwrite && apb_hit;

  master_latency_timer #(.WIDTH(8)) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .frame_active(frame_oe && !frame_n_out),
    .slice(slice),
    .expired(expired)
  );

  bus_parity_unit u_parity (
    .pclk(pclk),
    .presetn(presetn),
    .ad_drive(ad_oe),
    .ad_out(ad_out),
    .cbe_drive(cbe_oe),
    .cbe_n_out(cbe_n_out),
    .ad_in(ad_in),
    .cbe_n_in(cbe_n_in),
    .par_in(par_in),
    .check(check),
    .perr_en(ctrl[`CTRL_PERR_EN]),
    .par_out(par_out),
    .par_oe(par_oe),
    .perr_n_out(perr_n_out),
    .perr_oe(perr_oe),
    .error(parity_error)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      ctrl <= `CTRL_RESET;
      slice <= `LAT_RESET;
      perr_flag <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !apb_hit;
      if (psel && !penable) begin
        case (paddr)
          `CTRL_ADDR: prdata <= {30'h0, ctrl};
          `LAT_ADDR: prdata <= {24'h0, slice};
          `STAT_ADDR: prdata <= {24'h0, bufs, 1'b0, full, expired, perr_flag};
          default: prdata <= 32'h0;
        endcase
      end
      if (apb_wr && (paddr == `CTRL_ADDR)) begin
        ctrl <= pwdata[1:0];
      end
      if (apb_wr && (paddr == `LAT_ADDR)) begin
        slice <= pwdata[7:0];
      end
      if (parity_error) begin
        perr_flag <= 1'b1;
      end else if (apb_wr && (paddr == `STAT_ADDR) && pwdata[`STAT_PERR]) begin
        perr_flag <= 1'b0;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bufs <= 4'h0;
      post_strobe <= 1'b0;
      post_data <= 32'h0;
      post_be_n <= 4'hf;
    end else begin
      bufs <= bufs_next;
      post_strobe <= post_xfer;
      if (post_xfer) begin
        post_data <= ad_in;
        post_be_n <= cbe_n_in;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_state <= M_IDLE;
      t_state <= T_IDLE;
      m_pend <= 1'b0;
      m_write <= 1'b0;
      m_left <= 4'h0;
      m_devwait <= 3'h0;
      m_busy <= 1'b0;
      m_rvalid <= 1'b0;
      m_rdata <= 32'h0;
      req_n <= 1'b1;
      frame_prev <= 1'b1;
      frame_n_out <= 1'b1;
      frame_oe <= 1'b0;
      irdy_n_out <= 1'b1;
      irdy_oe <= 1'b0;
      trdy_n_out <= 1'b1;
      stop_n_out <= 1'b1;
      devsel_n_out <= 1'b1;
      target_oe <= 1'b0;
      ad_out <= 32'h0;
      ad_oe <= 1'b0;
      cbe_n_out <= 4'hf;
      cbe_oe <= 1'b0;
      t_write <= 1'b0;
      t_post <= 1'b0;
    end else begin
      frame_prev <= frame_n_in;
      m_rvalid <= 1'b0;
      if (m_start && (m_state == M_IDLE) && !m_pend) begin
        m_pend <= 1'b1;
        m_write <= m_cmd[0];
        m_left <= (m_phases == 4'h0) ? 4'h1 : m_phases;
        req_n <= 1'b0;
      end
      m_busy <= m_pend || (m_state != M_IDLE) || m_start;
      case (m_state)
        M_IDLE: begin
          if (m_pend && !gnt_n && frame_n_in && irdy_n_in && (t_state == T_IDLE)) begin
            m_state <= M_ADDR;
            m_pend <= 1'b0;
            req_n <= 1'b1;
            frame_n_out <= 1'b0;
            frame_oe <= 1'b1;
            ad_out <= m_addr;
            ad_oe <= 1'b1;
            cbe_n_out <= m_cmd;
            cbe_oe <= 1'b1;
          end
        end
        M_ADDR: begin
          m_state <= M_DATA;
          m_devwait <= 3'h0;
          irdy_n_out <= 1'b0;
          irdy_oe <= 1'b1;
          cbe_n_out <= 4'h0;
          ad_out <= m_write ? m_wdata : ad_out;
          ad_oe <= m_write;
          frame_n_out <= (m_left == 4'h1) || grant_lost;
        end
        M_DATA: begin
          if (devsel_n_in && (m_devwait != `DEVSEL_WAIT)) begin
            m_devwait <= m_devwait + 3'h1;
          end
          if (m_xfer) begin
            m_rvalid <= !m_write;
            m_rdata <= ad_in;
            m_left <= m_left - 4'h1;
          end
          if ((m_xfer && frame_n_out) || !stop_n_in || (devsel_n_in && (m_devwait == `DEVSEL_WAIT))) begin
            m_state <= M_TURN;
            frame_n_out <= 1'b1;
            irdy_n_out <= 1'b1;
            ad_oe <= 1'b0;
          end else begin
            if (m_xfer && m_write) begin
              ad_out <= m_wdata;
            end
            // Completion still waits for the target to be ready.
            if ((m_xfer && (m_left == 4'h2)) || grant_lost) begin
              frame_n_out <= 1'b1;
            end
          end
        end
        M_TURN: begin
          m_state <= M_IDLE;
          frame_oe <= 1'b0;
          irdy_oe <= 1'b0;
          cbe_oe <= 1'b0;
        end
        default: m_state <= M_IDLE;
      endcase
      case (t_state)
        T_IDLE: begin
          if (a_hit) begin
            t_write <= a_cmd[0];
            t_post <= a_post;
            devsel_n_out <= 1'b0;
            target_oe <= 1'b1;
            if (!a_cmd[0]) begin
              t_state <= T_RTURN;
            end else begin
              t_state <= T_DATA;
              if (a_post && !post_ok) begin
                stop_n_out <= 1'b0;
              end else begin
                trdy_n_out <= 1'b0;
                stop_n_out <= !(!a_post || frame_n_in) ? 1'b1 : a_post;
              end
            end
          end
        end
        T_RTURN: begin
          t_state <= T_DATA;
          ad_out <= t_rdata;
          ad_oe <= 1'b1;
          trdy_n_out <= 1'b0;
          stop_n_out <= 1'b0;
        end
        T_DATA: begin
          if (frame_n_in && !irdy_n_in && (t_xfer || !stop_n_out)) begin
            t_state <= T_BACK;
            trdy_n_out <= 1'b1;
            stop_n_out <= 1'b1;
            devsel_n_out <= 1'b1;
            ad_oe <= 1'b0;
          end else if (t_xfer) begin
            if (!t_post || (bufs_next == BUFFERS[3:0])) begin
              trdy_n_out <= 1'b1;
              stop_n_out <= 1'b0;
              ad_oe <= 1'b0;
            end
          end
        end
        T_BACK: begin
          t_state <= T_IDLE;
          target_oe <= 1'b0;
        end
        default: t_state <= T_IDLE;
      endcase
    end
  end
endmodule

// ==== verification/pci_parity_latency_ctrl_asserts.sv ====
`timescale 1ns/1ns
`include "pci_parity_latency_ctrl_map.vh"
module pci_plc_checker (
  input wire pclk,
  input wire presetn,
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire frame_n_in,
  input wire irdy_n_in,
  input wire frame_n_out,
  input wire frame_oe,
  input wire trdy_n_out,
  input wire stop_n_out,
  input wire target_oe,
  input wire gnt_n,
  input wire [31:0] ad_in,
  input wire [3:0] cbe_n_in,
  input wire ad_oe,
  input wire par_out,
  input wire par_oe,
  input wire perr_n_out,
  input wire perr_oe,
  input wire post_strobe
);
  reg [7:0] lat;
  reg [1:0] ctl;
  reg [8:0] cnt;
  reg fr;
  reg [3:0] cmd;
  wire wr = psel && penable && pready && pwrite;
  // Mirrors of the slice and control registers, and the command of the current cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat <= 8'h00;
      ctl <= 2'h0;
      cnt <= 9'h000;
      fr <= 1'b1;
      cmd <= 4'h0;
    end else begin
      if (wr && paddr == `LAT_ADDR) lat <= pwdata[7:0];
      if (wr && paddr == `CTRL_ADDR) ctl <= pwdata[1:0];
      cnt <= (frame_oe && !frame_n_out) ? cnt + 9'h001 : 9'h000;
      fr <= frame_n_in;
      if (fr && !frame_n_in) cmd <= cbe_n_in;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_par_even; par_oe |-> par_out == ^{$past(ad_in), $past(cbe_n_in)}; endproperty
  a_par_even: assert property (p_par_even) else $error("parity out wrong");
  property p_par_lag; par_oe == $past(ad_oe); endproperty
  a_par_lag: assert property (p_par_lag) else $error("parity enable lag wrong");
  property p_perr_en; perr_oe && !perr_n_out |-> ctl[0]; endproperty
  a_perr_en: assert property (p_perr_en) else $error("error line driven while disabled");
  property p_perr_shape; $fell(perr_n_out) |-> perr_oe ##1 (perr_oe && perr_n_out) ##1 !perr_oe; endproperty
  a_perr_shape: assert property (p_perr_shape) else $error("error line shape wrong");
  property p_mlt; frame_oe && !frame_n_out && gnt_n && cnt >= {1'b0, lat} + 9'h002 |-> ##[1:3] frame_n_out; endproperty
  a_mlt: assert property (p_mlt) else $error("expired master kept frame");
  property p_apb; psel && !penable |=> pready ##1 !pready; endproperty
  a_apb: assert property (p_apb) else $error("ready pulse wrong");
  property p_slverr; pready |-> pslverr == !(paddr == `CTRL_ADDR || paddr == `LAT_ADDR || paddr == `STAT_ADDR); endproperty
  a_slverr: assert property (p_slverr) else $error("slave error wrong");
  property p_rd_stop; target_oe && !trdy_n_out && cmd != `CMD_MEM_WRITE |-> !stop_n_out; endproperty
  a_rd_stop: assert property (p_rd_stop) else $error("no stop with first data");
  property p_post; post_strobe |-> ctl[1] && $past(target_oe && !trdy_n_out && !irdy_n_in); endproperty
  a_post: assert property (p_post) else $error("post without transfer");
  c_perr: cover property (perr_oe && !perr_n_out);
  c_post: cover property (post_strobe);
  c_stop: cover property (target_oe && !stop_n_out);
endmodule

// ==== verification/pci_bus_partner.sv ====
`timescale 1ns/1ns
module pci_bus_partner #(
  parameter [31:0] DATA = 32'h5a00_0000
) (
  input wire pclk,
  input wire presetn,
  input wire frame_n,
  input wire irdy_n,
  input wire fr_oe,
  input wire [3:0] cbe_n,
  input wire bad_par,
  input wire [1:0] slow,
  output reg devsel_n,
  output reg trdy_n,
  output wire [31:0] p_ad,
  output wire p_par
);
  reg act;
  reg oe;
  reg poe;
  reg par;
  reg [1:0] wt;
  reg [31:0] ad;
  // Released lines show the inverse of the last value, never a held copy.
  assign p_ad = oe ? ad : ~ad;
  assign p_par = poe ? par : ~par;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act <= 1'b0;
      oe <= 1'b0;
      poe <= 1'b0;
      par <= 1'b0;
      devsel_n <= 1'b1;
      trdy_n <= 1'b1;
      ad <= DATA;
    end else begin
      par <= ^{ad, cbe_n} ^ bad_par;
      poe <= oe;
      if (!act) begin
        if (fr_oe && !frame_n) begin
          act <= 1'b1;
          oe <= !cbe_n[0];
          devsel_n <= 1'b0;
          wt <= slow;
          ad <= DATA;
        end
      end else if ((!irdy_n && !trdy_n) || (frame_n && irdy_n)) begin
        trdy_n <= 1'b1;
        wt <= slow;
        ad <= ad + 32'h1;
        if (frame_n) begin
          act <= 1'b0;
          oe <= 1'b0;
          devsel_n <= 1'b1;
        end
      end else if (wt != 2'h0) begin
        wt <= wt - 2'h1;
      end else begin
        trdy_n <= 1'b0;
      end
    end
  end
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/1ns
`include "pci_parity_latency_ctrl_map.vh"
module tb;
  localparam NBUF = 4;
  reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg gnt_n = 1'b1, eisa_owned = 1'b0, buf_drain = 1'b0, m_start = 1'b0, bad_par = 1'b0, yank = 1'b0;
  reg m_fr = 1'b1, m_ir = 1'b1, m_oe = 1'b0, m_par = 1'b0, m_poe = 1'b0, pc = 1'b0;
  reg [3:0] m_cmd = 4'h0, m_phases = 4'h1, m_cbe = 4'hf;
  reg [31:0] pwdata = 32'h0, m_addr = 32'h1000_0000, m_wdata = 32'h0bad_0000, m_ad = 32'h0;
  reg [31:0] t_rdata = 32'hc3c3_0001, rd_q = 32'h0, pd = 32'h0;
  reg [1:0] slow = 2'h0;
  reg [11:0] cl = {`CMD_MEM_READ, `CMD_IO_READ, `CMD_IO_WRITE};
  integer error_cnt = 0, comparisons = 0, cyc = 0, xfer = 0, pst = 0, x = 0, i;
  wire [31:0] prdata, ad_out, post_data, m_rdata, p_ad;
  wire [3:0] cbe_n_out, post_be_n;
  wire pready, pslverr, req_n, frame_n_out, frame_oe, irdy_n_out, irdy_oe, trdy_n_out, stop_n_out;
  wire devsel_n_out, target_oe, ad_oe, cbe_oe, par_out, par_oe, perr_n_out, perr_oe, post_strobe;
  wire m_busy, m_rvalid, p_dev, p_trdy, p_par;
  wire frame_n_in = frame_oe ? frame_n_out : m_fr;
  wire irdy_n_in = irdy_oe ? irdy_n_out : m_ir;
  wire trdy_n_in = target_oe ? trdy_n_out : p_trdy;
  wire stop_n_in = target_oe ? stop_n_out : 1'b1;
  wire devsel_n_in = target_oe ? devsel_n_out : p_dev;
  wire [31:0] ad_in = ad_oe ? ad_out : (m_oe ? m_ad : p_ad);
  wire [3:0] cbe_n_in = cbe_oe ? cbe_n_out : m_cbe;
  wire par_in = par_oe ? par_out : (m_poe ? m_par : p_par);
  pci_parity_latency_ctrl #(.BUFFERS(NBUF)) u_pci_parity_latency_ctrl (.*);
  pci_bus_partner u_pci_bus_partner (.pclk, .presetn, .frame_n(frame_n_in), .irdy_n(irdy_n_in), .fr_oe(frame_oe),
    .cbe_n(cbe_n_in), .bad_par, .slow, .devsel_n(p_dev), .trdy_n(p_trdy), .p_ad, .p_par);
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    m_par <= ^{m_ad, m_cbe} ^ bad_par;
    m_poe <= m_oe;
    gnt_n <= !(!req_n || (frame_oe && !yank));
    if (irdy_oe && !irdy_n_in && !trdy_n_in) xfer = xfer + 1;
    if (post_strobe) pst = pst + 1;
    if (m_rvalid) rd_q = m_rdata;
    if (post_strobe) pd = post_data;
    cyc = cyc + 1;
    if (cyc > 20000) begin
      error_cnt = error_cnt + 1;
      test_done;
    end
  end
  task chk(input [31:0] g, input [31:0] e);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d, input [31:0] e, input se);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      if (!w) chk(prdata, e);
      chk({31'h0, pslverr}, {31'h0, se});
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task mtx(input [3:0] c, input [3:0] n);
    begin
      @(posedge pclk);
      m_start <= 1'b1;
      m_cmd <= c;
      m_phases <= n;
      xfer = 0;
      @(posedge pclk);
      m_start <= 1'b0;
      @(posedge pclk);
      while (m_busy !== 1'b0) @(posedge pclk);
      chk({31'h0, req_n}, 32'h1);
    end
  endtask
  task ttx(input [3:0] c, input integer n);
    begin
      @(posedge pclk);
      m_fr <= 1'b0;
      m_ad <= 32'h8000_0010;
      m_cbe <= c;
      m_oe <= 1'b1;
      x = 0;
      @(posedge pclk);
      m_ir <= 1'b0;
      m_fr <= (n == 1);
      m_cbe <= 4'h0;
      m_oe <= c[0];
      m_ad <= 32'h1234_0000;
      repeat (12) begin
        @(posedge pclk);
        if (pc) chk({31'h0, par_in}, {31'h0, ^t_rdata});
        pc = 1'b0;
        if (!m_ir) begin
          if (target_oe && !trdy_n_out) begin
            x = x + 1;
            m_ad <= m_ad + 32'h1;
            pc = !c[0];
            if (!c[0]) chk(ad_out, t_rdata);
          end
          if (m_fr && target_oe && !(trdy_n_out && stop_n_out)) begin
            m_ir <= 1'b1;
            m_oe <= 1'b0;
          end else if (!stop_n_out || x == n - 1) m_fr <= 1'b1;
        end
      end
      @(posedge pclk);
      m_ir <= 1'b1;
      m_fr <= 1'b1;
      m_oe <= 1'b0;
    end
  endtask
  task test_done;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `CTRL_ADDR, 32'h0, {30'h0, `CTRL_RESET}, 1'b0);
    apb(1'b0, `LAT_ADDR, 32'h0, {24'h0, `LAT_RESET}, 1'b0);
    apb(1'b0, `STAT_ADDR, 32'h0, 32'h0, 1'b0);
    apb(1'b1, `LAT_ADDR, 32'h2, 32'h0, 1'b0);
    apb(1'b1, `CTRL_ADDR, 32'h3, 32'h0, 1'b0);
    apb(1'b0, `LAT_ADDR, 32'h0, 32'h2, 1'b0);
    apb(1'b0, 12'h00c, 32'h0, 32'h0, 1'b1);
    $display("registers done");
    eisa_owned <= 1'b1;
    ttx(`CMD_MEM_WRITE, 6);
    chk(x, NBUF);
    chk(pst, NBUF);
    chk(pd, 32'h1234_0003);
    apb(1'b0, `STAT_ADDR, 32'h0, 32'h44, 1'b0);
    ttx(`CMD_MEM_WRITE, 1);
    chk(x, 0);
    repeat (NBUF) begin
      @(posedge pclk);
      buf_drain <= 1'b1;
      @(posedge pclk);
      buf_drain <= 1'b0;
    end
    eisa_owned <= 1'b0;
    ttx(`CMD_MEM_WRITE, 2);
    chk(x, 0);
    eisa_owned <= 1'b1;
    for (i = 0; i < 3; i = i + 1) begin
      ttx(cl[i * 4 +: 4], 3);
      chk(x, 1);
    end
    $display("target done");
    for (i = 0; i < 4; i = i + 1) begin
      apb(1'b1, `CTRL_ADDR, {30'h0, 1'b1, i[1]}, 32'h0, 1'b0);
      bad_par <= i[0];
      mtx(`CMD_MEM_READ, 4'h1);
      chk(rd_q, 32'h5a00_0000);
      apb(1'b0, `STAT_ADDR, 32'h0, {31'h0, i[0]}, 1'b0);
      apb(1'b1, `STAT_ADDR, 32'h1, 32'h0, 1'b0);
    end
    bad_par <= 1'b1;
    ttx(`CMD_IO_WRITE, 1);
    bad_par <= 1'b0;
    apb(1'b0, `STAT_ADDR, 32'h0, 32'h1, 1'b0);
    apb(1'b1, `STAT_ADDR, 32'h1, 32'h0, 1'b0);
    $display("parity done");
    slow <= 2'h1;
    for (i = 0; i < 2; i = i + 1) begin
      yank <= i[0];
      mtx(`CMD_MEM_WRITE, 4'h8);
      chk(xfer < 8, i);
    end
    $display("latency done");
    test_done;
  end
endmodule
bind pci_parity_latency_ctrl pci_plc_checker u_pci_plc_checker (.*);
